// [dled_regs.vh]
`ifndef DLED_REGS_VH
`define DLED_REGS_VH

// clock and timing
`define CLK_MHZ        200
`define SW_PERIOD_NS   1000
`define GATE_DELAY_NS  100
`define REFRESH_NS     50
`define BLANK_US       1000
`define MODE_WAIT      3'h7

// bus addresses
`define SA_ADDR        7'h60
`define BUS_ADDR_BASE  7'h60

// register sub-addresses
`define REG_STATUS     8'h00
`define REG_DIM1       8'h01
`define REG_DIM2       8'h02
`define REG_PWM_CMD    8'h03

// reset values
`define DIM_RESET      8'hFF
`define PWM_CMD_RESET  2'h0
`define STATUS_RESET   8'h00

// status field positions, channel 2 sits ST_CH_STRIDE above
`define ST_OV          0
`define ST_OPEN        1
`define ST_SHORT       2
`define ST_LEDOC       3
`define ST_CH_STRIDE   4

`endif

// [pin_sync.v]
`timescale 1ns/100ps
module pin_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             i_clock,
   input  wire             i_rstn,
   input  wire             i_clk_en,
   // raw pins and filtered levels
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_level
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg lvl_q;
         always @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               s1_q  <= 1'b0;
               s2_q  <= 1'b0;
               s3_q  <= 1'b0;
               lvl_q <= 1'b0;
            end else if (i_clk_en) begin
               s1_q <= i_async[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // a change counts only once two later stages agree
               if (s2_q == s3_q)
                  lvl_q <= s3_q;
            end
         end
         assign o_level[g] = lvl_q;
      end
   endgenerate

endmodule

// [buck_channel.v]
`timescale 1ns/100ps
`include "dled_regs.vh"
module buck_channel (
   // clock and reset
   input  wire i_clock,
   input  wire i_rstn,
   input  wire i_clk_en,
   // control
   input  wire i_enable,
   input  wire i_fault,
   input  wire i_set_pulse,
   // comparators
   input  wire i_trip,
   input  wire i_zero_current,
   input  wire i_bottom_oc,
   // switch drives
   output wire o_top_on,
   output wire o_bottom_on,
   output wire o_gate_drive
);

   localparam [31:0] REF_FULL  = (`REFRESH_NS * `CLK_MHZ + 999) / 1000 - 1;
   localparam [31:0] GATE_FULL = (`GATE_DELAY_NS * `CLK_MHZ + 999) / 1000 - 1;
   localparam [7:0]  REF_LAST  = REF_FULL[7:0];
   localparam [7:0]  GATE_LAST = GATE_FULL[7:0];
   localparam [1:0] C_OFF   = 2'h0;
   localparam [1:0] C_START = 2'h1;
   localparam [1:0] C_RUN   = 2'h2;

   reg [1:0] st_q;
   reg [7:0] cnt_q;
   reg [7:0] gcnt_q;
   reg       top_q;
   reg       bot_q;
   reg       gate_q;
   reg       pend_q;

   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q   <= C_OFF;
         cnt_q  <= 8'h00;
         gcnt_q <= 8'h00;
         top_q  <= 1'b0;
         bot_q  <= 1'b0;
         gate_q <= 1'b1;
         pend_q <= 1'b0;
      end else if (i_clk_en) begin
         if (!i_enable || i_fault) begin
            st_q   <= C_OFF;
            top_q  <= 1'b0;
            bot_q  <= 1'b0;
            gate_q <= 1'b1;
            gcnt_q <= 8'h00;
            pend_q <= 1'b0;
         end else begin
            if (gate_q) begin
               if (gcnt_q == GATE_LAST)
                  gate_q <= 1'b0;
               else
                  gcnt_q <= gcnt_q + 8'h01;
            end
            case (st_q)
               C_OFF: begin
                  st_q  <= C_START;
                  cnt_q <= 8'h00;
                  bot_q <= 1'b1;
               end
               C_START: begin
                  if (cnt_q == REF_LAST) begin
                     bot_q <= 1'b0;
                     top_q <= 1'b1;
                     st_q  <= C_RUN;
                  end else
                     cnt_q <= cnt_q + 8'h01;
               end
               C_RUN: begin
                  if (top_q) begin
                     if (i_trip) begin
                        top_q <= 1'b0;
                        bot_q <= ~i_zero_current;
                     end
                     if (i_set_pulse)
                        pend_q <= 1'b1;
                  end else if ((i_set_pulse || pend_q) && !i_bottom_oc &&
                               !i_trip) begin
                     // reset dominant: a set pulse never overrides a trip
                     // set pulse starts cycle
                     top_q  <= 1'b1;
                     bot_q  <= 1'b0;
                     pend_q <= 1'b0;
                  end else begin
                     if (i_set_pulse)
                        pend_q <= 1'b1;
                     if (i_zero_current)
                        bot_q <= 1'b0;
                  end
               end
               default: st_q <= C_OFF;
            endcase
         end
      end
   end

   assign o_top_on     = top_q;
   assign o_bottom_on  = bot_q;
   assign o_gate_drive = gate_q;

endmodule

// [dual_led_buck_control.v]
// Functional notes
// - dimming or channel_on low: both switches off, disconnect gate high.
// - on enable: bottom refresh, then top on; gate low after a longer delay.
// - oscillator set pulse turns top on; current trip resets it.
// - bottom stays on until next cycle or zero current.
// - bottom overcurrent holds off next cycle start until it clears.
// - open load: feedback high and sense low sets status bit 1 or 5.
// - feedback below short level after startup sets status bit 2 or 6.
// - short detection blanked for a while after enable input toggles.
// - any channel fault drives its disconnect gate high.
// - bus status word reports overvoltage, short, overcurrent, open load.
// - bus mode when any id pin is high, standalone when both low.
// - bus mode stays idle until a PWM command is written.
// - standalone starts on first dimming input rising edge.
// - standalone address 1100000; PWM registers not reachable there.
// - analog dim level scales threshold by (value+1)/256.
// - analog dim registers reset to 255.
// - feedback overvoltage: switches off, flag, alert, gate high.
// - alert held low while any alert present or latched.
`timescale 1ns/100ps
`include "dled_regs.vh"
module dual_led_buck_control #(
   parameter BLANK_CYCLES = `BLANK_US * `CLK_MHZ
) (
   // clock and reset
   input  wire       i_clock,
   input  wire       i_rstn,
   input  wire       i_clk_en,
   // control pins
   input  wire [1:0] i_dim_in,
   input  wire       i_enable_undervoltage_input,
   input  wire       i_bus_id_pin_a,
   input  wire       i_bus_id_pin_b,
   // analog comparator outputs, one bit per channel
   input  wire [1:0] i_current_trip,
   input  wire [1:0] i_zero_current,
   input  wire [1:0] i_bottom_overcurrent,
   input  wire [1:0] i_fb_open_level,
   input  wire [1:0] i_sense_low,
   input  wire [1:0] i_fb_short,
   input  wire [1:0] i_fb_overvoltage,
   input  wire [1:0] i_led_overcurrent,
   // serial bus
   input  wire       i_scl,
   input  wire       i_sda,
   output wire       o_sda_out,
   output wire       o_sda_oe_n,
   // alert, open drain
   output wire       o_alert_out,
   output wire       o_alert_oe_n,
   // power stage
   output wire [1:0] o_top_on,
   output wire [1:0] o_bottom_on,
   output wire [1:0] o_disconnect_gate_drive,
   output wire [8:0] o_ch1_dim_scale,
   output wire [8:0] o_ch2_dim_scale,
   output wire       o_bus_mode
);

   localparam NSY = 23;
   localparam [31:0] OSC_FULL = `SW_PERIOD_NS * `CLK_MHZ / 1000 - 1;
   localparam [11:0] OSC_LAST = OSC_FULL[11:0];
   localparam [31:0] BLANK_FULL = BLANK_CYCLES;
   localparam [19:0] BLANK_INIT = BLANK_FULL[19:0];
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_ADDR = 4'h1;
   localparam [3:0] S_SUB  = 4'h2;
   localparam [3:0] S_WR   = 4'h3;
   localparam [3:0] S_AACK = 4'h4;
   localparam [3:0] S_SACK = 4'h5;
   localparam [3:0] S_WACK = 4'h6;
   localparam [3:0] S_RD   = 4'h7;
   localparam [3:0] S_RACK = 4'h8;

   wire [NSY-1:0] lv;
   wire [1:0] led_oc = lv[1:0];
   wire [1:0] fb_ov  = lv[3:2];
   wire [1:0] fb_sh  = lv[5:4];
   wire [1:0] s_low  = lv[7:6];
   wire [1:0] fb_op  = lv[9:8];
   wire [1:0] b_oc   = lv[11:10];
   wire [1:0] zc     = lv[13:12];
   wire [1:0] trip   = lv[15:14];
   wire [1:0] dim    = lv[17:16];
   wire       scl    = lv[18];
   wire       sda    = lv[19];
   wire       en_uv  = lv[20];
   wire       id_a   = lv[21];
   wire       id_b   = lv[22];

   // comparator paths are synced too; the extra latency is the cost
   pin_sync #(.WIDTH(NSY)) u_sync (
      .i_clock  (i_clock),
      .i_rstn   (i_rstn),
      .i_clk_en (i_clk_en),
      .i_async  ({i_bus_id_pin_b, i_bus_id_pin_a,
                  i_enable_undervoltage_input, i_sda, i_scl, i_dim_in,
                  i_current_trip, i_zero_current, i_bottom_overcurrent,
                  i_fb_open_level, i_sense_low, i_fb_short,
                  i_fb_overvoltage, i_led_overcurrent}),
      .o_level  (lv)
   );

   reg [11:0] osc_q;
   reg        set_q;
   reg [19:0] blank_q;
   reg        en_prev_q;
   reg [2:0]  mcnt_q;
   reg        mode_done_q;
   reg        bus_mode_q;
   reg [1:0]  id_q;
   reg [7:0]  dim1_q;
   reg [7:0]  dim2_q;
   reg [1:0]  cmd_q;
   reg        cmd_seen_q;
   reg [7:0]  status_q;
   reg [1:0]  run_q;
   reg [1:0]  dim_prev_q;
   reg [8:0]  dsc1_q;
   reg [8:0]  dsc2_q;
   reg        alert_oe_n_q;
   reg        zero_q;
   reg [3:0]  st_q;
   reg [3:0]  bits_q;
   reg [7:0]  sh_q;
   reg [7:0]  ptr_q;
   reg        rw_q;
   reg        mack_q;
   reg        sda_oe_n_q;
   reg        scl_p_q;
   reg        sda_p_q;
   reg [7:0]  rd_byte;

   wire [7:0] live;
   wire [1:0] fault;
   wire [1:0] enable;

   // shared switching oscillator
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         osc_q <= 12'h000;
         set_q <= 1'b0;
      end else if (i_clk_en) begin
         if (osc_q == OSC_LAST) begin
            osc_q <= 12'h000;
            set_q <= 1'b1;
         end else begin
            osc_q <= osc_q + 12'h001;
            set_q <= 1'b0;
         end
      end
   end

   // start-up blanking and mode strap capture
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         blank_q     <= BLANK_INIT;
         en_prev_q   <= 1'b0;
         mcnt_q      <= 3'h0;
         mode_done_q <= 1'b0;
         bus_mode_q  <= 1'b0;
         id_q        <= 2'h0;
      end else if (i_clk_en) begin
         en_prev_q <= en_uv;
         if (en_uv != en_prev_q)
            blank_q <= BLANK_INIT;
         else if (blank_q != 20'h00000)
            blank_q <= blank_q - 20'h00001;
         // straps settle through the synchroniser before capture
         if (!mode_done_q) begin
            mcnt_q <= mcnt_q + 3'h1;
            if (mcnt_q == `MODE_WAIT) begin
               mode_done_q <= 1'b1;
               bus_mode_q  <= id_a | id_b;
               id_q        <= {id_b, id_a};
            end
         end
      end
   end

   // serial bus conditions
   wire start  = scl & scl_p_q & sda_p_q & ~sda;
   wire stop   = scl & scl_p_q & ~sda_p_q & sda;
   wire rise   = scl & ~scl_p_q;
   wire fall   = ~scl & scl_p_q;
   wire [6:0] my_addr = bus_mode_q ? (`BUS_ADDR_BASE | {5'h00, id_q})
                                   : `SA_ADDR;
   wire wr_en  = fall && (st_q == S_WR) && (bits_q == 4'h8);
   wire rd_ld  = fall && (((st_q == S_AACK) && rw_q) ||
                          ((st_q == S_RACK) && mack_q));
   wire st_clr = rd_ld && (ptr_q == `REG_STATUS);

   always @* begin
      case (ptr_q)
         `REG_STATUS:  rd_byte = status_q;
         `REG_DIM1:    rd_byte = dim1_q;
         `REG_DIM2:    rd_byte = dim2_q;
         `REG_PWM_CMD: rd_byte = bus_mode_q ? {6'h00, cmd_q} : 8'h00;
         default:      rd_byte = 8'h00;
      endcase
   end

   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q       <= S_IDLE;
         bits_q     <= 4'h0;
         sh_q       <= 8'h00;
         ptr_q      <= 8'h00;
         rw_q       <= 1'b0;
         mack_q     <= 1'b0;
         sda_oe_n_q <= 1'b1;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
      end else if (i_clk_en) begin
         scl_p_q <= scl;
         sda_p_q <= sda;
         if (start) begin
            st_q       <= S_ADDR;
            bits_q     <= 4'h0;
            sda_oe_n_q <= 1'b1;
         end else if (stop) begin
            st_q       <= S_IDLE;
            sda_oe_n_q <= 1'b1;
         end else if (rise) begin
            if ((st_q == S_ADDR) || (st_q == S_SUB) || (st_q == S_WR)) begin
               sh_q   <= {sh_q[6:0], sda};
               bits_q <= bits_q + 4'h1;
            end
            if (st_q == S_RACK)
               mack_q <= ~sda;
         end else if (fall) begin
            case (st_q)
               S_ADDR: if (bits_q == 4'h8) begin
                  if (sh_q[7:1] == my_addr && mode_done_q) begin
                     rw_q       <= sh_q[0];
                     sda_oe_n_q <= 1'b0;
                     st_q       <= S_AACK;
                  end else
                     st_q <= S_IDLE;
               end
               S_SUB: if (bits_q == 4'h8) begin
                  ptr_q      <= sh_q;
                  sda_oe_n_q <= 1'b0;
                  st_q       <= S_SACK;
               end
               S_WR: if (bits_q == 4'h8) begin
                  ptr_q      <= ptr_q + 8'h01;
                  sda_oe_n_q <= 1'b0;
                  st_q       <= S_WACK;
               end
               S_AACK, S_RACK: begin
                  if (rd_ld) begin
                     sh_q       <= rd_byte;
                     sda_oe_n_q <= rd_byte[7];
                     ptr_q      <= ptr_q + 8'h01;
                     bits_q     <= 4'h1;
                     st_q       <= S_RD;
                  end else begin
                     sda_oe_n_q <= 1'b1;
                     bits_q     <= 4'h0;
                     st_q       <= (st_q == S_AACK) ? S_SUB : S_IDLE;
                  end
               end
               S_SACK, S_WACK: begin
                  sda_oe_n_q <= 1'b1;
                  bits_q     <= 4'h0;
                  st_q       <= S_WR;
               end
               S_RD: begin
                  if (bits_q == 4'h8) begin
                     sda_oe_n_q <= 1'b1;
                     st_q       <= S_RACK;
                  end else begin
                     sh_q       <= {sh_q[6:0], 1'b0};
                     sda_oe_n_q <= sh_q[6];
                     bits_q     <= bits_q + 4'h1;
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end

   // register file
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         dim1_q     <= `DIM_RESET;
         dim2_q     <= `DIM_RESET;
         cmd_q      <= `PWM_CMD_RESET;
         cmd_seen_q <= 1'b0;
         dsc1_q     <= 9'h000;
         dsc2_q     <= 9'h000;
      end else if (i_clk_en) begin
         if (wr_en && ptr_q == `REG_DIM1)
            dim1_q <= sh_q;
         if (wr_en && ptr_q == `REG_DIM2)
            dim2_q <= sh_q;
         if (wr_en && ptr_q == `REG_PWM_CMD && bus_mode_q) begin
            cmd_q      <= sh_q[1:0];
            cmd_seen_q <= 1'b1;
         end
         dsc1_q <= {1'b0, dim1_q} + 9'h001;
         dsc2_q <= {1'b0, dim2_q} + 9'h001;
      end
   end

   genvar n;
   generate
      for (n = 0; n < 2; n = n + 1) begin : g_ch
         localparam B = n * `ST_CH_STRIDE;
         assign live[B+`ST_OV]    = fb_ov[n];
         assign live[B+`ST_OPEN]  = fb_op[n] & s_low[n];
         assign live[B+`ST_SHORT] = fb_sh[n] & (blank_q == 20'h00000);
         assign live[B+`ST_LEDOC] = led_oc[n];
         assign fault[n] = |live[B+3:B];
         wire ch_on = bus_mode_q ? cmd_q[n] : 1'b1;
         assign enable[n] = mode_done_q & run_q[n] & dim[n] & ch_on & en_uv;

         always @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               run_q[n]      <= 1'b0;
               dim_prev_q[n] <= 1'b0;
            end else if (i_clk_en) begin
               dim_prev_q[n] <= dim[n];
               if (mode_done_q && bus_mode_q && cmd_seen_q)
                  run_q[n] <= 1'b1;
               if (mode_done_q && !bus_mode_q && dim[n] && !dim_prev_q[n])
                  run_q[n] <= 1'b1;
            end
         end

         buck_channel u_ch (
            .i_clock        (i_clock),
            .i_rstn         (i_rstn),
            .i_clk_en       (i_clk_en),
            .i_enable       (enable[n]),
            .i_fault        (fault[n]),
            .i_set_pulse    (set_q),
            .i_trip         (trip[n]),
            .i_zero_current (zc[n]),
            .i_bottom_oc    (b_oc[n]),
            .o_top_on       (o_top_on[n]),
            .o_bottom_on    (o_bottom_on[n]),
            .o_gate_drive   (o_disconnect_gate_drive[n])
         );
      end
   endgenerate

   // status latch and alert
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         status_q     <= `STATUS_RESET;
         alert_oe_n_q <= 1'b1;
         zero_q       <= 1'b0;
      end else if (i_clk_en) begin
         // a read clears, but a condition still present sets again
         status_q <= (st_clr ? 8'h00 : status_q) | live;
         alert_oe_n_q <= ~((|status_q) | (|live));
      end
   end

   assign o_sda_out       = zero_q;
   assign o_sda_oe_n      = sda_oe_n_q;
   assign o_alert_out     = zero_q;
   assign o_alert_oe_n    = alert_oe_n_q;
   assign o_ch1_dim_scale = dsc1_q;
   assign o_ch2_dim_scale = dsc2_q;
   assign o_bus_mode      = bus_mode_q;

endmodule

// [dled_monitor.sv]
`timescale 1ns/100ps
module dled_monitor (
   input wire       i_clock,
   input wire       i_rstn,
   input wire [1:0] i_dim_in,
   input wire       i_bus_id_pin_a,
   input wire       i_bus_id_pin_b,
   input wire [1:0] i_current_trip,
   input wire [1:0] i_bottom_overcurrent,
   input wire [1:0] i_fb_overvoltage,
   input wire [1:0] o_top_on,
   input wire [1:0] o_bottom_on,
   input wire [1:0] o_disconnect_gate_drive,
   input wire       o_alert_oe_n,
   input wire [8:0] o_ch1_dim_scale,
   input wire       o_bus_mode
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   // straps are trusted only once capture has surely finished
   reg [4:0] up_q;
   always @(posedge i_clock or negedge i_rstn)
      if (!i_rstn)
         up_q <= 5'h00;
      else if (up_q != 5'h14)
         up_q <= up_q + 5'h01;
   AST_DIM_OFF: assert property (!i_dim_in[0] [*8] |->
      !o_top_on[0] && !o_bottom_on[0] && o_disconnect_gate_drive[0])
      else $error("channel active with dimming low");
   AST_REFRESH: assert property ($fell(o_disconnect_gate_drive[1]) |->
      $past(o_bottom_on[1], 12) && !$past(o_top_on[1], 12))
      else $error("no refresh before gate low");
   AST_TRIP: assert property (i_current_trip[0] [*8] |-> !o_top_on[0])
      else $error("top on while tripped");
   AST_OVERLAP: assert property ((o_top_on & o_bottom_on) == 2'h0)
      else $error("both switches on");
   AST_OC_HOLD: assert property (i_bottom_overcurrent[0] [*8] |->
      !$rose(o_top_on[0])) else $error("cycle started in overcurrent");
   AST_MODE: assert property (up_q == 5'h14 |->
      o_bus_mode == (i_bus_id_pin_a | i_bus_id_pin_b))
      else $error("wrong mode");
   AST_DIM_RESET: assert property (disable iff (1'b0)
      !i_rstn ##1 i_rstn [*2] |=> o_ch1_dim_scale == 9'h100)
      else $error("dim level not full after reset");
   AST_OV_OFF: assert property (i_fb_overvoltage[0] [*8] |->
      o_disconnect_gate_drive[0] && !o_top_on[0] && !o_bottom_on[0])
      else $error("overvoltage did not stop channel");
   AST_ALERT: assert property (
      (|i_fb_overvoltage) [*8] |-> !o_alert_oe_n)
      else $error("alert not pulled");
endmodule
bind dual_led_buck_control dled_monitor mon_u (
   .i_clock(i_clock), .i_rstn(i_rstn), .i_dim_in(i_dim_in),
   .i_bus_id_pin_a(i_bus_id_pin_a), .i_bus_id_pin_b(i_bus_id_pin_b),
   .i_current_trip(i_current_trip),
   .i_bottom_overcurrent(i_bottom_overcurrent),
   .i_fb_overvoltage(i_fb_overvoltage), .o_top_on(o_top_on),
   .o_bottom_on(o_bottom_on),
   .o_disconnect_gate_drive(o_disconnect_gate_drive),
   .o_alert_oe_n(o_alert_oe_n), .o_ch1_dim_scale(o_ch1_dim_scale),
   .o_bus_mode(o_bus_mode));

// [dled_bus_master.sv]
`timescale 1ns/100ps
module dled_bus_master (
   // clock and bus lines
   input  wire i_clock,
   input  wire i_sda,
   output reg  o_scl = 1'b1,
   output reg  o_sda_low = 1'b0
);
   task tk(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   // gap after scl falls keeps sda moves clear of false start or stop
   task drv(input logic d, input logic c);
      tk(4);
      o_sda_low = d;
      tk(12);
      o_scl = c;
      tk(12);
   endtask
   // ninth bit is always released: slave ack, or nack on reads
   task xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic [8:0] w;
      w = {d, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         drv(~w[i], 1'b1);
         w[i] = i_sda;
         o_scl = 1'b0;
      end
      q = w[8:1];
      ack = ~w[0];
   endtask
   task access(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d,
               input logic rd, output logic [7:0] q, output logic ack);
      logic [3:0] k;
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b0);
      xfer({a, 1'b0}, q, k[0]);
      xfer(s, q, k[1]);
      if (rd) begin
         drv(1'b0, 1'b1);
         drv(1'b1, 1'b0);
         xfer({a, 1'b1}, q, k[2]);
         xfer(8'hFF, q, k[3]);
      end
      else
         xfer(d, q, k[2]);
      drv(1'b1, 1'b1);
      drv(1'b0, 1'b1);
      ack = &k[2:0];
   endtask
endmodule

// [dual_led_buck_control_bench.sv]
`timescale 1ns/100ps
module dual_led_buck_control_bench;
   reg         i_clock, i_rstn, ida, en_pin, ack;
   reg  [1:0]  dim, trip, zc, boc, fbo, slow, fbs, ovp, loc;
   reg  [6:0]  addr;
   reg  [7:0]  q;
   reg  [3:0]  s;
   wire        scl, sda, sda_low, sda_out, sda_oe_n, al_oe_n, al_out, mode;
   wire [1:0]  top, bot, gate;
   wire [8:0]  sc1, sc2;
   wire [5:0]  outs = {gate, bot, top};
   integer     n_errors = 0, n_checks = 0, cyc = 0;
   dual_led_buck_control #(.BLANK_CYCLES(64)) dut_u (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(1'b1),
      .i_dim_in(dim), .i_enable_undervoltage_input(en_pin),
      .i_bus_id_pin_a(ida), .i_bus_id_pin_b(1'b0),
      .i_current_trip(trip), .i_zero_current(zc),
      .i_bottom_overcurrent(boc), .i_fb_open_level(fbo),
      .i_sense_low(slow), .i_fb_short(fbs), .i_fb_overvoltage(ovp),
      .i_led_overcurrent(loc), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_alert_out(al_out),
      .o_alert_oe_n(al_oe_n), .o_top_on(top), .o_bottom_on(bot),
      .o_disconnect_gate_drive(gate), .o_ch1_dim_scale(sc1),
      .o_ch2_dim_scale(sc2), .o_bus_mode(mode));
   dled_bus_master mst_u (.i_clock(i_clock), .i_sda(sda), .o_scl(scl),
      .o_sda_low(sda_low));
   // pull-up on the open-drain data line
   assign sda = (sda_oe_n | sda_out) & ~sda_low;
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         n_errors = n_errors + 1;
         tally_and_finish;
      end
   end
   task wt(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] sa, input logic [7:0] d, input logic ea);
      mst_u.access(addr, sa, d, 1'b0, q, ack);
      chk("ack", {8'h00, ack}, {8'h00, ea});
   endtask
   task rd(input logic [7:0] sa, input logic [7:0] e);
      mst_u.access(addr, sa, 8'h00, 1'b1, q, ack);
      chk("read", {1'b0, q}, {1'b0, e});
   endtask
   task wait_bit(input string nm, input int b, input logic v, input int n);
      for (int i = 0; i < n && outs[b] !== v; i++)
         wt(1);
      chk(nm, {8'h00, outs[b]}, {8'h00, v});
   endtask
   task watch(input int n);
      s = 4'h0;
      repeat (n) begin
         wt(1);
         s = s | {bot, top};
      end
   endtask
   task do_reset(input logic a);
      i_rstn = 1'b0;
      ida = a;
      wt(3);
      i_rstn = 1'b1;
      wt(20);
   endtask
   task t_bus_start;
      chk("mode", {8'h00, mode}, 9'h001);
      chk("scale2", sc2, 9'h100);
      rd(8'h01, 8'hFF);
      rd(8'h07, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(8'h01, 8'h01 << i, 1'b1);
         wt(2);
         chk("scale1", sc1, 9'h001 + (9'h001 << i));
      end
      rd(8'h01, 8'h80);
      dim = 2'b01;
      watch(300);
      chk("idle", {5'h00, s}, 9'h000);
      wr(8'h03, 8'h01, 1'b1);
      wait_bit("top", 0, 1'b1, 250);
      wt(15);
      chk("gate", {7'h00, gate}, 9'h002);
   endtask
   task t_trip_oc;
      trip[0] = 1'b1;
      wt(8);
      chk("trip", {5'h00, bot, top}, 9'h004);
      zc[0] = 1'b1;
      wt(8);
      chk("zero", {5'h00, bot, top}, 9'h000);
      boc[0] = 1'b1;
      trip[0] = 1'b0;
      zc[0] = 1'b0;
      watch(450);
      chk("hold", {8'h00, s[0]}, 9'h000);
      boc[0] = 1'b0;
      wait_bit("top", 0, 1'b1, 12);
   endtask
   task t_faults;
      logic [1:0] m;
      for (int k = 0; k < 8; k++) begin
         m = 2'b01 << (k / 4);
         ovp = (k % 4 == 0) ? m : 2'b00;
         fbo = (k % 4 == 1) ? m : 2'b00;
         slow = fbo;
         fbs = (k % 4 == 2) ? m : 2'b00;
         loc = (k % 4 == 3) ? m : 2'b00;
         wt(10);
         chk("gate", {7'h00, gate}, (k < 4) ? 9'h003 : 9'h002);
         chk("alert", {8'h00, al_oe_n | al_out}, 9'h000);
         {ovp, fbo, slow, fbs, loc} = 10'h000;
         wt(10);
         rd(8'h00, 8'h01 << k);
         rd(8'h00, 8'h00);
         chk("alert", {8'h00, al_oe_n}, 9'h001);
      end
   endtask
   task t_blank;
      en_pin = 1'b0;
      wt(8);
      en_pin = 1'b1;
      fbs = 2'b01;
      wt(20);
      fbs = 2'b00;
      wt(10);
      rd(8'h00, 8'h00);
   endtask
   task t_standalone;
      dim = 2'b00;
      do_reset(1'b0);
      chk("mode", {8'h00, mode}, 9'h000);
      wr(8'h02, 8'h10, 1'b0);
      addr = 7'h60;
      wr(8'h02, 8'h10, 1'b1);
      wt(2);
      chk("scale2", sc2, 9'h011);
      wr(8'h03, 8'h03, 1'b1);
      rd(8'h03, 8'h00);
      dim = 2'b10;
      wait_bit("bottom", 3, 1'b1, 12);
      chk("top", {8'h00, top[1]}, 9'h000);
      wait_bit("top", 1, 1'b1, 15);
      wt(15);
      chk("gate", {7'h00, gate}, 9'h001);
      dim = 2'b00;
      wt(8);
      chk("off", {3'h0, outs}, 9'h030);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {i_rstn, ida, dim, trip, zc, boc, fbo, slow, fbs, ovp, loc} = 0;
      en_pin = 1'b1;
      addr = 7'h61;
      do_reset(1'b1);
      t_bus_start;
      t_trip_oc;
      t_faults;
      t_blank;
      t_standalone;
      tally_and_finish;
   end
endmodule
